//--- core/lcdhi_pkg.sv
package lcdhi_pkg;
	// wishbone register map
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam logic [7:0] REG_CTRL_OFS = 8'h00;
	localparam logic [7:0] REG_STATUS_OFS = 8'h04;
	// control fields
	localparam int CTRL_EXT_BIT = 0;
	localparam logic CTRL_EXT_RST = 1'b0;
	// status fields
	localparam int STAT_PTR_LSB = 0;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_WIDTH_BIT = 8;
	localparam int STAT_GLYPH_BIT = 9;
	localparam int STAT_DIR_BIT = 10;
	localparam int STAT_PHASE_BIT = 11;
	localparam int STAT_ALT_BIT = 12;
	// instruction fields
	localparam int CMD_TEXT_ADDR_BIT = 7;
	localparam int CMD_GLYPH_ADDR_BIT = 6;
	localparam int CMD_FUNC_BIT = 5;
	localparam int CMD_WIDTH_BIT = 4;
	localparam int CMD_ENTRY_BIT = 2;
	localparam int CMD_DIR_BIT = 1;
	// reset values
	localparam logic WIDTH8_RST = 1'b1;
	localparam logic DIR_INC_RST = 1'b1;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int BUSY_TIME_NS = 4000;
	localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_PERIOD_NS = 4000;
	localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
	// extension driver
	localparam logic [6:0] SPILL_FIRST_COL = 7'h08;
	localparam logic [6:0] SPILL_LAST_COL = 7'h0F;
	localparam logic [2:0] DOTS_PER_CHAR = 3'h5;
	localparam logic [5:0] DOTS_PER_LINE = 6'h28;
	localparam logic [3:0] LINES_PER_FRAME = 4'hF;
	// host engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STORE = 2'b01,
		ST_FETCH = 2'b10,
		ST_LOAD = 2'b11
	} lcdhi_state_type;
endpackage

//--- core/lcdhi_ram.sv
`timescale 1ns/1ps
module lcdhi_ram (
	input wire logic clk,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:255];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

//--- core/lcdhi_top.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - register select high reaches the data register, low the instruction register
// - read/write high means read, low means write
// - 8-bit mode: lower lines carry low nibble; 4-bit mode: lower lines unused
// - 4-bit mode: upper lines carry both nibbles in two transfers
// - busy bit appears on the top data line during status read
// - bus width chosen by width bit written through instruction register
// - two 8-bit host registers: data holding and command latch
// - after a data read the next RAM location reloads the data register
// - after a data write the byte is copied into the addressed RAM
// - command latch is never returned on a host read
// - alternating polarity output for cascaded extension drivers
// - pixels beyond the 40th dot are shifted out serially
// - shift pulse and separate latch pulse accompany the serial data
// - timebase from internal divider or external clock on timebase input
// - status read: busy on top line, RAM pointer on lower seven lines
// - instruction refused while busy; host waits for busy to clear
// - RAM pointer steps by one after each access, per entry direction
module lcdhi_top (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic REGISTER_SELECT,
	input wire logic READ_WRITE,
	input wire logic XFER_STROBE,
	input wire logic [7:0] HOST_BUS_LINES_IN,
	output logic [7:0] HOST_BUS_LINES_OUT,
	output logic HOST_BUS_LINES_OE_N,
	input wire logic TIMEBASE_IN,
	output logic EXT_LATCH_PULSE,
	output logic EXT_SHIFT_PULSE,
	output logic ALT_POLARITY,
	output logic SPILL_DATA,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [lcdhi_pkg::WB_AW-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [lcdhi_pkg::WB_DW-1:0] WB_DAT_I,
	output logic [lcdhi_pkg::WB_DW-1:0] WB_DAT_O,
	output logic WB_ACK_O
);
	import lcdhi_pkg::*;

	function automatic logic [6:0] ptr_step(input logic [6:0] p, input logic inc,
		input logic glyph);
		logic [6:0] n;
		n = inc ? p + 7'h01 : p - 7'h01;
		ptr_step = glyph ? {1'b0, n[5:0]} : n;
	endfunction

	// pin synchronisers
	logic [11:0] meta_ff;
	logic [11:0] sync_ff;
	logic stb_d_ff;
	logic tb_d_ff;
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			meta_ff <= 12'h000;
			sync_ff <= 12'h000;
			stb_d_ff <= 1'b0;
			tb_d_ff <= 1'b0;
		end else begin
			meta_ff <= {HOST_BUS_LINES_IN, TIMEBASE_IN, XFER_STROBE, READ_WRITE, REGISTER_SELECT};
			sync_ff <= meta_ff;
			stb_d_ff <= sync_ff[2];
			tb_d_ff <= sync_ff[3];
		end
	end
	wire regsel_s = sync_ff[0];
	wire rdwr_s = sync_ff[1];
	wire stb_s = sync_ff[2];
	wire tb_s = sync_ff[3];
	wire [7:0] bus_s = sync_ff[11:4];
	wire stb_rise = stb_s & ~stb_d_ff;
	wire stb_fall = ~stb_s & stb_d_ff;

	// host registers and state
	lcdhi_state_type state_ff, nxt_state;
	logic width8_ff;
	logic dir_inc_ff;
	logic glyph_sel_ff;
	logic [6:0] ptr_ff;
	logic [7:0] dhr_ff;
	logic [7:0] cmd_ff;
	logic [3:0] hi_nib_ff;
	logic phase_ff;
	logic [7:0] busy_cnt_ff;
	logic [7:0] ram_rdata;

	wire busy_bit = (busy_cnt_ff != 8'h00) | (state_ff != ST_IDLE);
	wire last_half = width8_ff | phase_ff;
	wire wr_done = stb_fall & ~rdwr_s & last_half;
	wire rd_done = stb_fall & rdwr_s & last_half;
	wire [7:0] wr_byte = width8_ff ? bus_s : {hi_nib_ff, bus_s[7:4]};
	wire instr_ok = wr_done & ~regsel_s & ~busy_bit;
	wire data_wr = wr_done & regsel_s & (state_ff == ST_IDLE);
	wire data_rd = rd_done & regsel_s & (state_ff == ST_IDLE);
	wire set_addr = instr_ok & (wr_byte[CMD_TEXT_ADDR_BIT] | wr_byte[CMD_GLYPH_ADDR_BIT]);
	wire [7:0] rd_byte = regsel_s ? dhr_ff : {busy_bit, ptr_ff};
	wire [7:0] rd_hi = {rd_byte[7:4], 4'h0};
	wire [7:0] rd_lo = {rd_byte[3:0], 4'h0};
	wire [7:0] rd_lane = width8_ff ? rd_byte : (phase_ff ? rd_lo : rd_hi);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (data_wr) begin
					nxt_state = ST_STORE;
				end else if (data_rd | set_addr) begin
					nxt_state = ST_FETCH;
				end
			end
			ST_STORE: nxt_state = ST_IDLE;
			ST_FETCH: nxt_state = ST_LOAD;
			ST_LOAD: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// instruction decode
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			cmd_ff <= 8'h00;
			width8_ff <= WIDTH8_RST;
			dir_inc_ff <= DIR_INC_RST;
			busy_cnt_ff <= 8'h00;
		end else if (instr_ok) begin
			cmd_ff <= wr_byte;
			busy_cnt_ff <= 8'(BUSY_CYCLES);
			if (wr_byte[7:5] == 3'b001) begin
				width8_ff <= wr_byte[CMD_WIDTH_BIT];
			end
			if (wr_byte[7:2] == 6'b000001) begin
				dir_inc_ff <= wr_byte[CMD_DIR_BIT];
			end
		end else if (busy_cnt_ff != 8'h00) begin
			busy_cnt_ff <= busy_cnt_ff - 8'h01;
		end
	end

	// pointer, data holding register
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ptr_ff <= 7'h00;
			glyph_sel_ff <= 1'b0;
			dhr_ff <= 8'h00;
		end else begin
			if (set_addr) begin
				glyph_sel_ff <= ~wr_byte[CMD_TEXT_ADDR_BIT];
				ptr_ff <= wr_byte[CMD_TEXT_ADDR_BIT] ? wr_byte[6:0] : {1'b0, wr_byte[5:0]};
			end else if ((state_ff == ST_STORE) | data_rd) begin
				ptr_ff <= ptr_step(ptr_ff, dir_inc_ff, glyph_sel_ff);
			end
			if (data_wr) begin
				dhr_ff <= wr_byte;
			end else if (state_ff == ST_LOAD) begin
				dhr_ff <= ram_rdata;
			end
		end
	end

	// nibble pairing and bus drive
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			phase_ff <= 1'b0;
			hi_nib_ff <= 4'h0;
		end else begin
			if (instr_ok & (wr_byte[7:5] == 3'b001)) begin
				phase_ff <= 1'b0;
			end else if (stb_fall & ~width8_ff) begin
				phase_ff <= ~phase_ff;
			end
			if (stb_fall & ~rdwr_s & ~width8_ff & ~phase_ff) begin
				hi_nib_ff <= bus_s[7:4];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			HOST_BUS_LINES_OUT <= 8'h00;
			HOST_BUS_LINES_OE_N <= 1'b1;
		end else if (stb_rise & rdwr_s) begin
			HOST_BUS_LINES_OUT <= rd_lane;
			HOST_BUS_LINES_OE_N <= 1'b0;
		end else if (stb_fall) begin
			HOST_BUS_LINES_OE_N <= 1'b1;
		end
	end

	// text and glyph memory
	logic [6:0] spill_col_ff;
	logic spill_rd_ff;
	logic [2:0] spill_cnt_ff;
	wire spill_rd = (state_ff == ST_IDLE) & (spill_cnt_ff == 3'h0) & ~spill_rd_ff;
	wire ram_we = state_ff == ST_STORE;
	wire [7:0] ram_addr = (state_ff == ST_IDLE) ? {1'b0, spill_col_ff} : {glyph_sel_ff, ptr_ff};

	lcdhi_ram u_ram (
		.clk(CORE_CLK),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(dhr_ff),
		.rdata(ram_rdata)
	);

	// timebase
	logic ext_sel_ff;
	logic [7:0] div_cnt_ff;
	wire div_wrap = div_cnt_ff == 8'(OSC_DIV_CYCLES - 1);
	wire tick = ext_sel_ff ? (tb_s & ~tb_d_ff) : div_wrap;
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			div_cnt_ff <= 8'h00;
		end else begin
			div_cnt_ff <= div_wrap ? 8'h00 : div_cnt_ff + 8'h01;
		end
	end

	// extension driver
	logic [4:0] spill_sh_ff;
	logic [5:0] dot_ff;
	logic [3:0] line_ff;
	wire launch = tick & ~EXT_SHIFT_PULSE & ~EXT_LATCH_PULSE & (spill_cnt_ff != 3'h0);
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			spill_rd_ff <= 1'b0;
			spill_col_ff <= SPILL_FIRST_COL;
			spill_sh_ff <= 5'h00;
			spill_cnt_ff <= 3'h0;
		end else begin
			spill_rd_ff <= spill_rd;
			if (spill_rd_ff) begin
				spill_sh_ff <= ram_rdata[4:0];
				spill_cnt_ff <= DOTS_PER_CHAR;
				spill_col_ff <= (spill_col_ff == SPILL_LAST_COL) ? SPILL_FIRST_COL :
					spill_col_ff + 7'h01;
			end else if (launch) begin
				spill_sh_ff <= {spill_sh_ff[3:0], 1'b0};
				spill_cnt_ff <= spill_cnt_ff - 3'h1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			EXT_SHIFT_PULSE <= 1'b0;
			EXT_LATCH_PULSE <= 1'b0;
			ALT_POLARITY <= 1'b0;
			SPILL_DATA <= 1'b0;
			dot_ff <= 6'h00;
			line_ff <= 4'h0;
		end else if (tick) begin
			if (EXT_SHIFT_PULSE) begin
				EXT_SHIFT_PULSE <= 1'b0;
				if (dot_ff == DOTS_PER_LINE) begin
					EXT_LATCH_PULSE <= 1'b1;
					dot_ff <= 6'h00;
					line_ff <= (line_ff == LINES_PER_FRAME) ? 4'h0 : line_ff + 4'h1;
					if (line_ff == LINES_PER_FRAME) begin
						ALT_POLARITY <= ~ALT_POLARITY;
					end
				end
			end else if (EXT_LATCH_PULSE) begin
				EXT_LATCH_PULSE <= 1'b0;
			end else if (launch) begin
				SPILL_DATA <= spill_sh_ff[4];
				EXT_SHIFT_PULSE <= 1'b1;
				dot_ff <= dot_ff + 6'h01;
			end
		end
	end

	// wishbone slave
	wire wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire ctrl_hit = WB_ADR_I == REG_CTRL_OFS;
	wire stat_hit = WB_ADR_I == REG_STATUS_OFS;
	wire [31:0] ctrl_word = {31'h0000_0000, ext_sel_ff};
	wire [31:0] stat_word = {19'h0_0000, ALT_POLARITY, phase_ff, dir_inc_ff, glyph_sel_ff,
		width8_ff, busy_bit, ptr_ff};
	wire [31:0] rd_word = ctrl_hit ? ctrl_word : (stat_hit ? stat_word : 32'h0000_0000);
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
			ext_sel_ff <= CTRL_EXT_RST;
		end else begin
			WB_ACK_O <= wb_hit;
			if (wb_hit & ~WB_WE_I) begin
				WB_DAT_O <= rd_word;
			end
			if (wb_hit & WB_WE_I & ctrl_hit & WB_SEL_I[0]) begin
				ext_sel_ff <= WB_DAT_I[CTRL_EXT_BIT];
			end
		end
	end

	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_fetch_load;
		state_ff == ST_FETCH ##1 state_ff == ST_LOAD;
	endsequence

	a_data_route: assert property (data_wr |=> state_ff == ST_STORE && ram_we)
		else $error("data write not routed to ram");
	a_instr_latch: assert property (instr_ok |=> cmd_ff == $past(wr_byte))
		else $error("instruction not latched");
	a_read_drive: assert property (stb_rise && rdwr_s |=>
		!HOST_BUS_LINES_OE_N && HOST_BUS_LINES_OUT == $past(rd_lane))
		else $error("read cycle not driven");
	a_write_quiet: assert property (stb_rise && !rdwr_s && HOST_BUS_LINES_OE_N
		|=> HOST_BUS_LINES_OE_N)
		else $error("write cycle drove bus");
	a_fall_release: assert property (stb_fall |=> HOST_BUS_LINES_OE_N)
		else $error("bus drive not ended");
	a_status_top: assert property (stb_rise && rdwr_s && !regsel_s && width8_ff |=>
		HOST_BUS_LINES_OUT[7] == $past(busy_bit) && HOST_BUS_LINES_OUT[6:0] == $past(ptr_ff))
		else $error("status byte wrong");
	a_nibble_first: assert property (stb_fall && !width8_ff && !phase_ff
		&& state_ff == ST_IDLE |=> state_ff == ST_IDLE && phase_ff && $stable(cmd_ff))
		else $error("acted on first nibble");
	a_read_refetch: assert property (data_rd |=> s_fetch_load ##1
		dhr_ff == $past(ram_rdata))
		else $error("data register not reloaded");
	a_store_step: assert property (state_ff == ST_STORE |=>
		ptr_ff == ptr_step($past(ptr_ff), $past(dir_inc_ff), $past(glyph_sel_ff)))
		else $error("pointer not stepped");
	a_busy_block: assert property (wr_done && !regsel_s && busy_bit |=> $stable(cmd_ff))
		else $error("instruction taken while busy");
	a_latch_alone: assert property (EXT_LATCH_PULSE |-> !EXT_SHIFT_PULSE)
		else $error("latch overlaps shift");
endmodule

//--- testbench/lcdhi_host_model.sv
`timescale 1ns/1ps
module lcdhi_host_model (
	input wire logic clk,
	output logic rs,
	output logic rw,
	output logic stb,
	output logic [7:0] bus,
	input wire logic [7:0] dev_out,
	input wire logic dev_oe_n
);
	logic drv = 1'b0;
	logic wide = 1'b1;
	logic [7:0] dh = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] lowq;
	initial begin
		rs = 1'b0;
		rw = 1'b1;
		stb = 1'b0;
	end
	// released lines toggle, no keeper
	// 4-bit mode leaves the lower lines open
	assign bus = !dev_oe_n ? dev_out : (drv ? (wide ? dh : {dh[7:4], ~last[3:0]}) : ~last);
	always @(posedge clk) begin
		last <= bus;
	end
	task automatic one(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		rs <= r;
		rw <= w;
		drv <= !w;
		dh <= d;
		@(posedge clk);
		stb <= 1'b1;
		repeat (6) @(posedge clk);
		q = bus;
		stb <= 1'b0;
		repeat (5) @(posedge clk);
		drv <= 1'b0;
	endtask
	task automatic xb(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (wide) begin
			one(r, w, d, q);
		end else begin
			one(r, w, d, hi);
			one(r, w, {d[3:0], d[7:4]}, lo);
			q = {hi[7:4], lo[7:4]};
			lowq = {hi[3:0], lo[3:0]};
		end
	endtask
	task automatic ready(output logic [7:0] s);
		for (int i = 0; i < 20; i++) begin
			xb(1'b0, 1'b1, 8'h00, s);
			if (!s[7]) break;
		end
	endtask
	task automatic op(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] s;
		ready(s);
		xb(r, w, d, q);
	endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import lcdhi_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tbase = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [WB_AW-1:0] adr = '0;
	logic [WB_DW-1:0] wdat = '0;
	logic [3:0] sel = 4'h0;
	logic [3:0] sel_v = 4'hF;
	logic [WB_DW-1:0] rdat, w;
	logic ack, rs, rw, xs, oe_n, lat, sh, alt, spill;
	logic [7:0] bus, dout, q, p, d;
	logic [7:0] mem [8:15];
	logic arm = 0, arm_ok = 0, alt_ok = 0, alt_chk = 0, lat_q = 0, sh_q = 0, alt_q = 0;
	logic [39:0] bits = '0;
	int n_mismatch = 0, num_checks = 0, cnt = 0, lat_n = 0;
	lcdhi_top uut (.CORE_CLK(clk), .SYS_RST(rst), .REGISTER_SELECT(rs), .READ_WRITE(rw),
		.XFER_STROBE(xs), .HOST_BUS_LINES_IN(bus), .HOST_BUS_LINES_OUT(dout),
		.HOST_BUS_LINES_OE_N(oe_n), .TIMEBASE_IN(tbase), .EXT_LATCH_PULSE(lat),
		.EXT_SHIFT_PULSE(sh), .ALT_POLARITY(alt), .SPILL_DATA(spill), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack));
	lcdhi_host_model host (.clk(clk), .rs(rs), .rw(rw), .stb(xs), .bus(bus), .dev_out(dout),
		.dev_oe_n(oe_n));
	initial begin
		forever #50 clk = ~clk;
	end
	initial begin
		#37;
		forever #600 tbase = ~tbase;
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] v,
		output logic [31:0] r);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		sel <= sel_v;
		adr <= a;
		wdat <= v;
		for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk);
		if (i == 50) n_mismatch++;
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		@(posedge clk);
	endtask
	function automatic logic [39:0] exp_bits();
		logic [39:0] b = '0;
		for (int c = 8; c < 16; c++) b = {b[34:0], mem[c][4:0]};
		return b;
	endfunction
	// extension link monitor
	always @(posedge clk) begin
		sh_q <= sh;
		lat_q <= lat;
		alt_q <= alt;
		if (sh && !sh_q) begin
			bits <= {bits[38:0], spill};
			cnt <= cnt + 1;
		end
		if (lat && !lat_q) begin
			if (arm_ok) begin
				chk(cnt, 40);
				chk(bits, exp_bits());
			end
			arm_ok <= arm;
			cnt <= 0;
			lat_n <= lat_n + 1;
		end
		if (alt !== alt_q && arm_ok) begin
			if (alt_ok) begin
				chk(lat_n + int'(lat && !lat_q), 16);
				alt_chk <= 1'b1;
			end
			alt_ok <= 1'b1;
			lat_n <= 0;
		end
	end
	initial begin
		w = $urandom(32'h8f80);
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, REG_STATUS_OFS, 0, w);
		chk(w, 32'h0000_0500);
		wb(1'b1, 8'h08, $urandom, w);
		wb(1'b0, 8'h08, 0, w);
		chk(w, 0);
		wb(1'b1, REG_CTRL_OFS, 32'h0000_0001, w);
		wb(1'b0, REG_CTRL_OFS, 0, w);
		chk(w, 32'h0000_0001);
		sel_v = 4'hE;
		wb(1'b1, REG_CTRL_OFS, 32'h0000_0000, w);
		sel_v = 4'hF;
		wb(1'b0, REG_CTRL_OFS, 0, w);
		chk(w, 32'h0000_0001);
		host.op(1'b0, 1'b0, 8'h88, q);
		for (int i = 8; i < 16; i++) begin
			mem[i] = 8'($urandom);
			host.op(1'b1, 1'b0, mem[i], q);
		end
		host.ready(q);
		chk(q, 8'h10);
		arm <= 1'b1;
		host.op(1'b0, 1'b0, 8'h88, q);
		for (int i = 8; i < 16; i++) begin
			host.op(1'b1, 1'b1, 8'h00, q);
			chk(q, mem[i]);
		end
		p = 8'($urandom_range(16, 79));
		host.op(1'b0, 1'b0, 8'h80 | p, q);
		host.xb(1'b0, 1'b1, 8'h00, q);
		chk(q[7], 1'b1);
		host.xb(1'b0, 1'b0, 8'h80 | (p + 8'h01), q);
		host.ready(q);
		chk(q, p);
		host.op(1'b0, 1'b0, 8'h04, q);
		host.op(1'b0, 1'b0, 8'h80 | p, q);
		host.op(1'b1, 1'b0, 8'($urandom), q);
		host.ready(q);
		chk(q, p - 8'h01);
		host.op(1'b0, 1'b0, 8'h06, q);
		d = 8'($urandom);
		p = 8'($urandom_range(0, 62));
		host.op(1'b0, 1'b0, 8'h40 | p, q);
		host.op(1'b1, 1'b0, d, q);
		host.op(1'b0, 1'b0, 8'h40 | p, q);
		host.op(1'b1, 1'b1, 8'h00, q);
		chk(q, d);
		host.ready(q);
		chk(q, p + 8'h01);
		host.op(1'b0, 1'b0, 8'h20, q);
		host.wide = 1'b0;
		wb(1'b0, REG_STATUS_OFS, 0, w);
		chk(w[STAT_WIDTH_BIT], 1'b0);
		for (int k = 0; k < 4; k++) begin
			p = 8'($urandom_range(16, 79));
			d = (k == 0) ? 8'hA5 : 8'($urandom);
			host.op(1'b0, 1'b0, 8'h80 | p, q);
			host.op(1'b1, 1'b0, d, q);
			host.op(1'b0, 1'b0, 8'h80 | p, q);
			host.op(1'b1, 1'b1, 8'h00, q);
			chk(q, d);
			chk(host.lowq, 8'h00);
		end
		host.op(1'b0, 1'b0, 8'h30, q);
		host.wide = 1'b1;
		wb(1'b0, REG_STATUS_OFS, 0, w);
		chk(w[STAT_WIDTH_BIT], 1'b1);
		for (int i = 0; i < 60000 && !alt_chk; i++) @(posedge clk);
		if (!alt_chk) n_mismatch++;
		close_out();
	end
	initial begin
		#(100 * 90000);
		n_mismatch++;
		close_out();
	end
endmodule
